//--- shared/ptp_qual_pkg.sv
// shared types of the packet qualifier
package ptp_qual_pkg;
	typedef logic [7:0] byte_t;
	typedef logic [15:0] word_t;
	typedef struct packed {
		logic [3:0] mtype;
		logic [15:0] seq;
		logic [11:0] hash;
	} entry_t;
endpackage

//--- shared/ptp_qual_regs.svh
// register offsets, field positions, reset values and encodings of the packet qualifier
`ifndef PTP_QUAL_REGS_SVH
`define PTP_QUAL_REGS_SVH

`define ADDR_CLASS_CTRL 8'h00
`define ADDR_CRIT_MASK 8'h01
`define ADDR_CRIT_MATCH 8'h02
`define ADDR_CRIT_OFFSET 8'h03
`define ADDR_COMMIT 8'h04
`define ADDR_TYPE_EN 8'h05
`define ADDR_SRC_CHECK 8'h06
`define ADDR_TIMING_ONE 8'h07
`define ADDR_EVENT_FLAGS 8'h08
`define ADDR_LIVE_STATUS 8'h09
`define ADDR_EQ_ID 8'h0A
`define ADDR_EQ_SEQ 8'h0B
`define ADDR_IQ_ID 8'h0C
`define ADDR_IQ_SEQ 8'h0D
`define ADDR_HDR_OFFSET 8'h0E

`define CC_OR_BIT 0
`define CC_START_LO 4
`define CC_START_HI 7
`define CC_VER_LO 8
`define CC_VER_HI 11

`define OFFSET_EN_BIT 15
`define COMMIT_BIT 7
`define COMMIT_STROBE 16'h0080
`define COMMIT_HDR_WORD 16'h008F
`define SEL_HDR_OFF 4'hF
`define NUM_CRIT 8

`define SRC_SOURCE_CHECK_ENABLE_BIT 15
`define VLAN_SEL_BIT 0

`define START_OFF 4'h0
`define START_FIRST 4'h1
`define START_IP4_UDP 4'hD
`define START_IP6_UDP 4'hE
`define START_ANY_UDP 4'hF

`define HDR_SUM_FIRST 6'h14
`define HDR_SUM_LAST 6'h1D
`define HDR_SEQ_HI 6'h1E
`define HDR_SEQ_LO 6'h1F
`define HDR_V1_CTRL 6'h20
`define HDR_REL_MAX 6'h3F

`define PTP_V1 4'h1
`define PTP_V2 4'h2
`define V1_EVENT_LIMIT 4'h2

`define RST_CLASS_CTRL 16'h0020
`define RST_TYPE_EN 16'h0000
`define RST_WORD 16'h0000
`endif

//--- tb/mac_stream_model.sv
// stand-in for the mac side and fixed matcher: drives one packet byte stream
`timescale 1ns/1ps
`default_nettype none
module mac_stream_model (
	input wire logic sys_clk,
	output logic valid,
	output logic [7:0] data,
	output logic sop,
	output logic eop,
	output logic [15:0] landmark,
	output logic ptp_start,
	output logic fixed_qual,
	output logic [11:0] vlan_id
);
	localparam int HDR = 14;
	initial begin
		valid = 1'b0;
		data = 8'h00;
		sop = 1'b0;
		eop = 1'b0;
		landmark = 16'h0000;
		ptp_start = 1'b0;
		fixed_qual = 1'b0;
		vlan_id = 12'h000;
	end
	// one byte per edge; lm picks the landmark bit raised on byte 5 (0 raises bit 0, which no start code uses)
	task automatic send(input logic [7:0] p [0:47], input logic fq, input logic [3:0] lm,
		input logic [11:0] vid);
		for (int i = 0; i < 48; i++) begin
			@(posedge sys_clk);
			valid <= 1'b1;
			data <= p[i];
			sop <= (i == 0);
			eop <= (i == 47);
			landmark <= (i == 5) ? (16'h0001 << lm) : 16'h0000;
			ptp_start <= (i == HDR);
			fixed_qual <= (i == 47) ? fq : ~fq;
			vlan_id <= (i == 47) ? vid : ~vid;
		end
		@(posedge sys_clk);
		// released lines must not keep showing the last values
		valid <= 1'b0;
		data <= ~p[47];
		sop <= 1'b0;
		eop <= 1'b0;
		ptp_start <= 1'b0;
		fixed_qual <= ~fq;
		vlan_id <= ~vid;
	endtask
endmodule
`default_nettype wire

//--- tb/ptp_packet_qualifier_test.sv
// self-checking bench of the packet qualifier
`timescale 1ns/1ps
`default_nettype none
`include "ptp_qual_regs.svh"
module ptp_packet_qualifier_test;
	typedef struct packed {
		logic [3:0] ver;
		logic [3:0] mt;
		logic fq;
		logic [7:0] en;
		logic ex;
	} row_t;
	row_t rows [14] = '{'{4'h2, 4'h0, 1'b1, 8'hFF, 1'b1}, '{4'h2, 4'h1, 1'b1, 8'hFF, 1'b1},
		'{4'h2, 4'h2, 1'b1, 8'hFF, 1'b1}, '{4'h2, 4'h3, 1'b1, 8'hFF, 1'b1},
		'{4'h2, 4'h4, 1'b1, 8'hFF, 1'b1}, '{4'h2, 4'h5, 1'b1, 8'hFF, 1'b1},
		'{4'h2, 4'h6, 1'b1, 8'hFF, 1'b1}, '{4'h2, 4'h7, 1'b1, 8'hFF, 1'b1},
		'{4'h2, 4'h8, 1'b1, 8'hFF, 1'b0}, '{4'h1, 4'h0, 1'b1, 8'hFF, 1'b1},
		'{4'h1, 4'h1, 1'b1, 8'hFF, 1'b1}, '{4'h1, 4'h2, 1'b1, 8'hFF, 1'b0},
		'{4'h2, 4'h3, 1'b1, 8'hF7, 1'b0}, '{4'h2, 4'h0, 1'b0, 8'hFF, 1'b0}};
	logic sys_clk, rst, ce, reg_wr, reg_rd, vsel;
	logic [7:0] reg_addr;
	logic [15:0] reg_wdata, reg_rdata, cur_seq;
	logic [3:0] cur_mt;
	logic [7:0] pkt [0:47];
	logic eg_valid, eg_sop, eg_eop, eg_ptp_start, eg_fixed_qual;
	logic ing_valid, ing_sop, ing_eop, ing_ptp_start, ing_fixed_qual;
	logic [7:0] eg_data, ing_data;
	logic [15:0] eg_landmark, ing_landmark;
	logic [11:0] eg_vlan_id, ing_vlan_id;
	int fail_count = 0;
	int compares = 0;
	ptp_packet_qualifier u_ptp_packet_qualifier (.sys_clk(sys_clk), .rst(rst), .ce(ce),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .eg_valid(eg_valid), .eg_data(eg_data), .eg_sop(eg_sop),
		.eg_eop(eg_eop), .eg_landmark(eg_landmark), .eg_ptp_start(eg_ptp_start),
		.eg_fixed_qual(eg_fixed_qual), .eg_vlan_id(eg_vlan_id), .ing_valid(ing_valid),
		.ing_data(ing_data), .ing_sop(ing_sop), .ing_eop(ing_eop),
		.ing_landmark(ing_landmark), .ing_ptp_start(ing_ptp_start),
		.ing_fixed_qual(ing_fixed_qual), .ing_vlan_id(ing_vlan_id));
	mac_stream_model u_eg (.sys_clk(sys_clk), .valid(eg_valid), .data(eg_data), .sop(eg_sop),
		.eop(eg_eop), .landmark(eg_landmark), .ptp_start(eg_ptp_start),
		.fixed_qual(eg_fixed_qual), .vlan_id(eg_vlan_id));
	mac_stream_model u_ing (.sys_clk(sys_clk), .valid(ing_valid), .data(ing_data),
		.sop(ing_sop), .eop(ing_eop), .landmark(ing_landmark), .ptp_start(ing_ptp_start),
		.fixed_qual(ing_fixed_qual), .vlan_id(ing_vlan_id));
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic wrap_up;
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [15:0] exp);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, exp);
	endtask
	function automatic logic [11:0] hash_of();
		logic [11:0] h;
		h = 12'h000;
		for (int k = 34; k < 44; k++) h = h + {4'h0, pkt[k]};
		return h;
	endfunction
	// header at byte 14: version byte 15, v2 type byte 14, v1 type byte 46, seq 44..45
	task automatic build(input logic [3:0] ver, input logic [3:0] mt, input logic [15:0] sq);
		for (int i = 0; i < 48; i++) pkt[i] = 8'h30 + 8'(i);
		pkt[15] = {4'h0, ver};
		pkt[14] = {4'h0, mt};
		pkt[46] = {4'h0, mt};
		pkt[44] = sq[15:8];
		pkt[45] = sq[7:0];
		cur_mt = mt;
		cur_seq = sq;
	endtask
	// send one packet, then check status and pop the entry if one is expected
	task automatic run(input logic ing, input logic fq, input logic [3:0] lm,
		input logic [11:0] vid, input logic ex);
		if (ing) u_ing.send(pkt, fq, lm, vid);
		else u_eg.send(pkt, fq, lm, vid);
		repeat (4) @(posedge sys_clk);
		rd(`ADDR_LIVE_STATUS, {14'h0000, ex & ing, ex & ~ing});
		if (ex) begin
			rd(ing ? `ADDR_IQ_ID : `ADDR_EQ_ID, {cur_mt, vsel ? vid : hash_of()});
			rd(ing ? `ADDR_IQ_SEQ : `ADDR_EQ_SEQ, cur_seq);
		end
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		#100us;
		fail_count++;
		wrap_up();
	end
	initial begin
		rst = 1'b1;
		ce = 1'b1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 16'h0000;
		vsel = 1'b0;
		repeat (3) @(posedge sys_clk);
		rst <= 1'b0;
		rd(`ADDR_CLASS_CTRL, `RST_CLASS_CTRL);
		rd(`ADDR_EVENT_FLAGS, 16'h0000);
		rd(8'h3F, 16'h0000);
		wr(`ADDR_CLASS_CTRL, 16'h0210);
		foreach (rows[i]) begin
			build(rows[i].ver, rows[i].mt, 16'h0100 + 16'(i));
			wr(`ADDR_TYPE_EN, {8'h00, rows[i].en});
			run(1'b0, rows[i].fq, 4'h0, 12'h000, rows[i].ex);
		end
		// overflow on the ninth entry, then drain
		wr(`ADDR_EVENT_FLAGS, 16'h000F);
		wr(`ADDR_TYPE_EN, 16'hFFFF);
		build(4'h2, 4'h1, 16'h0200);
		repeat (9) u_eg.send(pkt, 1'b1, 4'h0, 12'h000);
		repeat (4) @(posedge sys_clk);
		rd(`ADDR_EVENT_FLAGS, 16'h0005);
		for (int i = 0; i < 8; i++) rd(`ADDR_EQ_SEQ, 16'h0200);
		rd(`ADDR_LIVE_STATUS, 16'h0000);
		rd(`ADDR_EQ_SEQ, 16'h0000);
		wr(`ADDR_EVENT_FLAGS, 16'h000F);
		rd(`ADDR_EVENT_FLAGS, 16'h0000);
		// one criterion on the first two bytes, earlier byte high
		wr(`ADDR_CRIT_MASK, 16'hFFFF);
		wr(`ADDR_CRIT_MATCH, 16'h3031);
		wr(`ADDR_CRIT_OFFSET, 16'h8000);
		wr(`ADDR_COMMIT, `COMMIT_STROBE);
		run(1'b0, 1'b1, 4'h0, 12'h000, 1'b1);
		pkt[0] = 8'h31;
		pkt[1] = 8'h30;
		run(1'b0, 1'b1, 4'h0, 12'h000, 1'b0);
		wr(`ADDR_CRIT_MATCH, 16'h3130);
		wr(`ADDR_COMMIT, 16'h0000);
		run(1'b0, 1'b1, 4'h0, 12'h000, 1'b0);
		wr(`ADDR_COMMIT, `COMMIT_STROBE);
		run(1'b0, 1'b1, 4'h0, 12'h000, 1'b1);
		// start after ipv4 ethertype: element absent or present
		build(4'h2, 4'h3, 16'h0300);
		wr(`ADDR_CLASS_CTRL, 16'h0280);
		run(1'b0, 1'b1, 4'h0, 12'h000, 1'b1);
		run(1'b0, 1'b1, 4'h8, 12'h000, 1'b0);
		wr(`ADDR_CLASS_CTRL, 16'h0200);
		run(1'b0, 1'b1, 4'h8, 12'h000, 1'b1);
		// ingress source identity check
		wr(`ADDR_SRC_CHECK, {4'h8, hash_of() + 12'h001});
		run(1'b1, 1'b1, 4'h0, 12'h000, 1'b0);
		wr(`ADDR_SRC_CHECK, {4'h8, hash_of()});
		run(1'b1, 1'b1, 4'h0, 12'h000, 1'b1);
		wr(`ADDR_TIMING_ONE, 16'h0001);
		vsel = 1'b1;
		wr(`ADDR_SRC_CHECK, 16'h8ABC);
		run(1'b1, 1'b1, 4'h0, 12'hABC, 1'b1);
		// or mode from the end of a udp header, ptp header eight bytes on
		wr(`ADDR_CRIT_MATCH, 16'h3637);
		wr(`ADDR_COMMIT, `COMMIT_STROBE);
		wr(`ADDR_CRIT_OFFSET, 16'h0008);
		wr(`ADDR_COMMIT, `COMMIT_HDR_WORD);
		rd(`ADDR_HDR_OFFSET, 16'h0008);
		wr(`ADDR_CLASS_CTRL, 16'h02F1);
		run(1'b0, 1'b0, 4'hD, 12'h5A5, 1'b1);
		run(1'b0, 1'b0, 4'hE, 12'h5A5, 1'b1);
		run(1'b0, 1'b0, 4'h0, 12'h5A5, 1'b0);
		run(1'b0, 1'b1, 4'h0, 12'h5A5, 1'b1);
		build(4'h1, 4'h0, 16'h0400);
		run(1'b0, 1'b0, 4'hD, 12'h5A5, 1'b0);
		// frozen clock enable: a write is not taken
		ce <= 1'b0;
		wr(`ADDR_TIMING_ONE, 16'h0000);
		ce <= 1'b1;
		rd(`ADDR_TIMING_ONE, 16'h0001);
		// reset again in mid-run
		rst <= 1'b1;
		@(posedge sys_clk);
		rst <= 1'b0;
		rd(`ADDR_CLASS_CTRL, `RST_CLASS_CTRL);
		rd(`ADDR_TIMING_ONE, 16'h0000);
		wrap_up();
	end
endmodule
`default_nettype wire

//--- verilog/ptp_packet_qualifier.sv
// packet qualifier: programmable matcher, event decode and timestamp identity queues
// Function
// - start code 15 references end of either IPv4/UDP or IPv6/UDP header.
// - eight masked 16-bit criteria, each at own byte offset from start.
// - combine bit 0: fixed verdict and every enabled criterion required.
// - codes 2-15: criteria apply only when named element is present.
// - and mode, code 1: criteria apply to all packets from first byte.
// - and mode ignores header offset; fixed matcher marks header start.
// - combine bit 1: fixed verdict or fixed-up-to-start plus criteria.
// - or mode, code 1: criteria form independent path from first byte.
// - or mode programmable path also needs matching version field.
// - commit word 0x0080 strobes; selector 15 stores header offset.
// - offset register bit 0x8000 enables; low bits hold byte offset.
// - version 1: type from control field, types 0 and 1 are events.
// - version 2: type from 4-bit field, types 0 to 7 are events.
// - message type never taken from udp port number.
// - per-type per-direction enables gate queue writes.
// - each queue holds eight entries; software drains fast enough.
// - write to full queue sets sticky overflow flag.
// - live not-empty status plus sticky empty-to-not-empty flag.
// - entries written regardless of check sequence errors.
// - source check: ingress entry only if identity equals expected code.
// - identity is 12-bit sum of header bytes 20-29, or outer vlan id.
// - code 0 disables, 1 first byte, 2-14 after specific elements.
//
// Our own choices: the register offsets and the address-and-strobe port.
`include "ptp_qual_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module ptp_packet_qualifier #(
	parameter int QDEPTH = 8
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic [7:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	input wire logic eg_valid,
	input wire logic [7:0] eg_data,
	input wire logic eg_sop,
	input wire logic eg_eop,
	input wire logic [15:0] eg_landmark,
	input wire logic eg_ptp_start,
	input wire logic eg_fixed_qual,
	input wire logic [11:0] eg_vlan_id,
	input wire logic ing_valid,
	input wire logic [7:0] ing_data,
	input wire logic ing_sop,
	input wire logic ing_eop,
	input wire logic [15:0] ing_landmark,
	input wire logic ing_ptp_start,
	input wire logic ing_fixed_qual,
	input wire logic [11:0] ing_vlan_id
);
	////////////////////////////////////////////////////////////////////////////////
	// per-direction views of the packet streams (index 0 egress, 1 ingress)
	logic [1:0] s_valid, s_sop, s_eop, s_ptp_start, s_fixed_qual;
	logic [1:0][7:0] s_data;
	logic [1:0][15:0] s_landmark;
	logic [1:0][11:0] s_vlan;
	assign s_valid = {ing_valid, eg_valid};
	assign s_sop = {ing_sop, eg_sop};
	assign s_eop = {ing_eop, eg_eop};
	assign s_ptp_start = {ing_ptp_start, eg_ptp_start};
	assign s_fixed_qual = {ing_fixed_qual, eg_fixed_qual};
	assign s_data = {ing_data, eg_data};
	assign s_landmark = {ing_landmark, eg_landmark};
	assign s_vlan = {ing_vlan_id, eg_vlan_id};

	////////////////////////////////////////////////////////////////////////////////
	// configuration registers
	logic cmb_or_r, cmb_or_nxt;
	logic [3:0] start_r, start_nxt, ver_r, ver_nxt;
	ptp_qual_pkg::word_t mask_r, mask_nxt, match_r, match_nxt, offs_r, offs_nxt;
	ptp_qual_pkg::word_t type_en_r, type_en_nxt;
	logic source_check_enable_r, source_check_enable_nxt, vlan_sel_r, vlan_sel_nxt;
	logic [11:0] exp_hash_r, exp_hash_nxt;
	logic [14:0] hdr_off_r, hdr_off_nxt;
	ptp_qual_pkg::word_t crit_mask_r [`NUM_CRIT];
	ptp_qual_pkg::word_t crit_mask_nxt [`NUM_CRIT];
	ptp_qual_pkg::word_t crit_match_r [`NUM_CRIT];
	ptp_qual_pkg::word_t crit_match_nxt [`NUM_CRIT];
	logic [14:0] crit_off_r [`NUM_CRIT];
	logic [14:0] crit_off_nxt [`NUM_CRIT];
	logic [`NUM_CRIT-1:0] crit_en_r, crit_en_nxt;
	logic [3:0] flags_r, flags_nxt;
	logic [1:0] ne_prev_r, ne_prev_nxt;
	ptp_qual_pkg::word_t rdata_r, rdata_nxt;
	logic [3:0] sel;
	logic commit;
	logic eg_ovf_clr;
	localparam ptp_qual_pkg::word_t cc_reset = `RST_CLASS_CTRL;

	logic [1:0] q_ne, q_full, q_ovf, q_pop;
	ptp_qual_pkg::entry_t q_head [2];

	assign sel = reg_wdata[3:0];
	assign commit = reg_wr && (reg_addr == `ADDR_COMMIT) && reg_wdata[`COMMIT_BIT];
	assign eg_ovf_clr = ce && reg_wr && (reg_addr == `ADDR_EVENT_FLAGS) && reg_wdata[0];
	assign q_pop[0] = reg_rd && (reg_addr == `ADDR_EQ_SEQ);
	assign q_pop[1] = reg_rd && (reg_addr == `ADDR_IQ_SEQ);

	always_comb begin
		cmb_or_nxt = cmb_or_r;
		start_nxt = start_r;
		ver_nxt = ver_r;
		mask_nxt = mask_r;
		match_nxt = match_r;
		offs_nxt = offs_r;
		type_en_nxt = type_en_r;
		source_check_enable_nxt = source_check_enable_r;
		exp_hash_nxt = exp_hash_r;
		vlan_sel_nxt = vlan_sel_r;
		hdr_off_nxt = hdr_off_r;
		crit_mask_nxt = crit_mask_r;
		crit_match_nxt = crit_match_r;
		crit_off_nxt = crit_off_r;
		crit_en_nxt = crit_en_r;
		flags_nxt = flags_r;
		if (reg_wr) begin
			case (reg_addr)
				`ADDR_CLASS_CTRL: begin
					cmb_or_nxt = reg_wdata[`CC_OR_BIT];
					start_nxt = reg_wdata[`CC_START_HI:`CC_START_LO];
					ver_nxt = reg_wdata[`CC_VER_HI:`CC_VER_LO];
				end
				`ADDR_CRIT_MASK: mask_nxt = reg_wdata;
				`ADDR_CRIT_MATCH: match_nxt = reg_wdata;
				`ADDR_CRIT_OFFSET: offs_nxt = reg_wdata;
				`ADDR_COMMIT: begin
					if (commit && (sel == `SEL_HDR_OFF)) begin
						hdr_off_nxt = offs_r[14:0];
					end else if (commit && (sel[3] == 1'b0)) begin
						crit_mask_nxt[sel[2:0]] = mask_r;
						crit_match_nxt[sel[2:0]] = match_r;
						crit_off_nxt[sel[2:0]] = offs_r[14:0];
						crit_en_nxt[sel[2:0]] = offs_r[`OFFSET_EN_BIT];
					end
				end
				`ADDR_TYPE_EN: type_en_nxt = reg_wdata;
				`ADDR_SRC_CHECK: begin
					source_check_enable_nxt = reg_wdata[`SRC_SOURCE_CHECK_ENABLE_BIT];
					exp_hash_nxt = reg_wdata[11:0];
				end
				`ADDR_TIMING_ONE: vlan_sel_nxt = reg_wdata[`VLAN_SEL_BIT];
				`ADDR_EVENT_FLAGS: flags_nxt = flags_r & ~reg_wdata[3:0];
				default: flags_nxt = flags_r;
			endcase
		end
		// hardware set wins over a clear in the same cycle
		flags_nxt = flags_nxt | {q_ne & ~ne_prev_r, q_ovf};
		ne_prev_nxt = q_ne;
	end

	always_comb begin
		rdata_nxt = `RST_WORD;
		if (reg_rd) begin
			case (reg_addr)
				`ADDR_CLASS_CTRL: rdata_nxt = {4'h0, ver_r, start_r, 3'h0, cmb_or_r};
				`ADDR_CRIT_MASK: rdata_nxt = mask_r;
				`ADDR_CRIT_MATCH: rdata_nxt = match_r;
				`ADDR_CRIT_OFFSET: rdata_nxt = offs_r;
				`ADDR_TYPE_EN: rdata_nxt = type_en_r;
				`ADDR_SRC_CHECK: rdata_nxt = {source_check_enable_r, 3'h0, exp_hash_r};
				`ADDR_TIMING_ONE: rdata_nxt = {15'h0000, vlan_sel_r};
				`ADDR_EVENT_FLAGS: rdata_nxt = {12'h000, flags_r};
				`ADDR_LIVE_STATUS: rdata_nxt = {14'h0000, q_ne};
				`ADDR_EQ_ID: rdata_nxt = q_ne[0] ? {q_head[0].mtype, q_head[0].hash} : `RST_WORD;
				`ADDR_EQ_SEQ: rdata_nxt = q_ne[0] ? q_head[0].seq : `RST_WORD;
				`ADDR_IQ_ID: rdata_nxt = q_ne[1] ? {q_head[1].mtype, q_head[1].hash} : `RST_WORD;
				`ADDR_IQ_SEQ: rdata_nxt = q_ne[1] ? q_head[1].seq : `RST_WORD;
				`ADDR_HDR_OFFSET: rdata_nxt = {1'b0, hdr_off_r};
				default: rdata_nxt = `RST_WORD;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			cmb_or_r <= cc_reset[`CC_OR_BIT];
			start_r <= cc_reset[`CC_START_HI:`CC_START_LO];
			ver_r <= cc_reset[`CC_VER_HI:`CC_VER_LO];
			mask_r <= `RST_WORD;
			match_r <= `RST_WORD;
			offs_r <= `RST_WORD;
			type_en_r <= `RST_TYPE_EN;
			source_check_enable_r <= 1'b0;
			exp_hash_r <= 12'h000;
			vlan_sel_r <= 1'b0;
			hdr_off_r <= 15'h0000;
			for (int i = 0; i < `NUM_CRIT; i++) begin
				crit_mask_r[i] <= `RST_WORD;
				crit_match_r[i] <= `RST_WORD;
				crit_off_r[i] <= 15'h0000;
			end
			crit_en_r <= '0;
			flags_r <= 4'h0;
			ne_prev_r <= 2'b00;
			rdata_r <= `RST_WORD;
		end else if (ce) begin
			cmb_or_r <= cmb_or_nxt;
			start_r <= start_nxt;
			ver_r <= ver_nxt;
			mask_r <= mask_nxt;
			match_r <= match_nxt;
			offs_r <= offs_nxt;
			type_en_r <= type_en_nxt;
			source_check_enable_r <= source_check_enable_nxt;
			exp_hash_r <= exp_hash_nxt;
			vlan_sel_r <= vlan_sel_nxt;
			hdr_off_r <= hdr_off_nxt;
			crit_mask_r <= crit_mask_nxt;
			crit_match_r <= crit_match_nxt;
			crit_off_r <= crit_off_nxt;
			crit_en_r <= crit_en_nxt;
			flags_r <= flags_nxt;
			ne_prev_r <= ne_prev_nxt;
			rdata_r <= rdata_nxt;
		end
	end
	assign reg_rdata = rdata_r;

	hdr_offset_a: assert property (@(posedge sys_clk) disable iff (rst)
		(ce && reg_wr && reg_addr == `ADDR_COMMIT && reg_wdata == `COMMIT_HDR_WORD)
		|=> hdr_off_r == $past(offs_r[14:0]))
		else $error("header offset not stored by commit selector 15");
	crit_commit_a: assert property (@(posedge sys_clk) disable iff (rst)
		(ce && commit && sel[3] == 1'b0)
		|=> crit_en_r[$past(sel[2:0])] == $past(offs_r[`OFFSET_EN_BIT])
		&& crit_mask_r[$past(sel[2:0])] == $past(mask_r))
		else $error("criterion commit did not store enable or mask");
	ovf_sticky_a: assert property (@(posedge sys_clk) disable iff (rst)
		(ce && q_ovf[0]) |=> flags_r[0] and (!eg_ovf_clr |=> flags_r[0]))
		else $error("egress overflow flag not set or not sticky");
	ne_latch_a: assert property (@(posedge sys_clk) disable iff (rst)
		(ce && q_ne[1] && !ne_prev_r[1]) |=> flags_r[3])
		else $error("ingress not-empty transition not latched");

	////////////////////////////////////////////////////////////////////////////////
	// per-direction matcher, header decode and queue
	for (genvar d = 0; d < 2; d++) begin : dir_g
		logic armed_r, armed_nxt, seen_r, seen_nxt, hact_r, hact_nxt, push_r, push_nxt;
		logic [15:0] rel_r, rel_nxt, seq_r, seq_nxt;
		logic [7:0] prev_r, prev_nxt, b0_r, b0_nxt, b1_r, b1_nxt, ctl_r, ctl_nxt;
		logic [5:0] hrel_r, hrel_nxt;
		logic [11:0] sum_r, sum_nxt, hash;
		logic [`NUM_CRIT-1:0] ok_r, ok_nxt;
		ptp_qual_pkg::entry_t entry_r, entry_nxt;
		logic lm_hit, cur_armed, ptp_hit, cur_hact, evaluated, all_ok, qual, is_event;
		logic [15:0] cur_rel;
		logic [5:0] cur_hrel;
		logic [3:0] mtype;
		logic [7:0] dir_en;

		assign dir_en = (d == 0) ? type_en_r[7:0] : type_en_r[15:8];

		always_comb begin
			armed_nxt = armed_r;
			seen_nxt = seen_r;
			hact_nxt = hact_r;
			rel_nxt = rel_r;
			hrel_nxt = hrel_r;
			prev_nxt = prev_r;
			b0_nxt = b0_r;
			b1_nxt = b1_r;
			ctl_nxt = ctl_r;
			seq_nxt = seq_r;
			sum_nxt = sum_r;
			ok_nxt = ok_r;
			push_nxt = 1'b0;
			entry_nxt = entry_r;
			hash = 12'h000;
			mtype = 4'h0;
			is_event = 1'b0;
			evaluated = 1'b0;
			all_ok = 1'b0;
			qual = 1'b0;
			if (start_r == `START_ANY_UDP) begin
				lm_hit = s_landmark[d][`START_IP4_UDP] | s_landmark[d][`START_IP6_UDP];
			end else begin
				lm_hit = (start_r > `START_FIRST) && s_landmark[d][start_r];
			end
			// code 1 arms on the first byte itself, codes 2-15 on the byte after their landmark, code 0 never
			cur_armed = s_sop[d] ? (start_r == `START_FIRST) : armed_r;
			cur_rel = s_sop[d] ? 16'h0000 : rel_r;
			if (cmb_or_r) begin
				// the fixed path still marks its own header start in or mode
				ptp_hit = s_ptp_start[d] || (cur_armed && (cur_rel == {1'b0, hdr_off_r}));
			end else begin
				ptp_hit = s_ptp_start[d];
			end
			cur_hact = ptp_hit || (hact_r && !s_sop[d]);
			cur_hrel = ptp_hit ? 6'h00 : hrel_r;
			if (s_valid[d]) begin
				if (s_sop[d]) begin
					seen_nxt = 1'b0;
					ok_nxt = '0;
					sum_nxt = 12'h000;
					b0_nxt = 8'h00;
					b1_nxt = 8'h00;
					ctl_nxt = 8'h00;
					seq_nxt = 16'h0000;
				end
				if (cur_armed) begin
					seen_nxt = 1'b1;
				end
				for (int i = 0; i < `NUM_CRIT; i++) begin
					if (crit_en_r[i] && cur_armed && (cur_rel == {1'b0, crit_off_r[i]} + 16'h0001)
						&& ((({prev_r, s_data[d]} ^ crit_match_r[i]) & crit_mask_r[i]) == 16'h0000)) begin
						ok_nxt[i] = 1'b1;
					end
				end
				if (cur_hact) begin
					case (cur_hrel)
						6'h00: b0_nxt = s_data[d];
						6'h01: b1_nxt = s_data[d];
						`HDR_SEQ_HI: seq_nxt[15:8] = s_data[d];
						`HDR_SEQ_LO: seq_nxt[7:0] = s_data[d];
						`HDR_V1_CTRL: ctl_nxt = s_data[d];
						default: ctl_nxt = ctl_nxt;
					endcase
					if (cur_hrel >= `HDR_SUM_FIRST && cur_hrel <= `HDR_SUM_LAST) begin
						sum_nxt = sum_nxt + 12'(s_data[d]);
					end
					hrel_nxt = (cur_hrel == `HDR_REL_MAX) ? cur_hrel : cur_hrel + 6'h01;
				end
				hact_nxt = cur_hact && !s_eop[d];
				armed_nxt = (cur_armed || lm_hit) && !s_eop[d];
				rel_nxt = lm_hit ? 16'h0000 : cur_rel + 16'h0001;
				prev_nxt = s_data[d];
				if (s_eop[d]) begin
					// not-evaluated packets keep the fixed verdict alone
					evaluated = (start_r != `START_OFF) && seen_nxt;
					all_ok = &(ok_nxt | ~crit_en_r);
					if (cmb_or_r) begin
						qual = s_fixed_qual[d] || (evaluated && all_ok && !cur_hact == 1'b0
							&& (b1_nxt[3:0] == ver_r));
					end else begin
						qual = s_fixed_qual[d] && (!evaluated || all_ok);
					end
					// type comes from header fields only, never from port numbers
					if (b1_nxt[3:0] == `PTP_V1) begin
						mtype = ctl_nxt[3:0];
						is_event = mtype < `V1_EVENT_LIMIT;
					end else if (b1_nxt[3:0] == `PTP_V2) begin
						mtype = b0_nxt[3:0];
						is_event = (mtype[3] == 1'b0);
					end
					hash = vlan_sel_r ? s_vlan[d] : sum_nxt;
					// no check sequence status is consulted here
					push_nxt = qual && is_event && dir_en[mtype[2:0]]
						&& ((d == 0) || !source_check_enable_r || (hash == exp_hash_r));
					entry_nxt = '{mtype: mtype, seq: seq_nxt, hash: hash};
				end
			end
		end

		always_ff @(posedge sys_clk) begin
			if (rst) begin
				armed_r <= 1'b0;
				seen_r <= 1'b0;
				hact_r <= 1'b0;
				rel_r <= 16'h0000;
				hrel_r <= 6'h00;
				prev_r <= 8'h00;
				b0_r <= 8'h00;
				b1_r <= 8'h00;
				ctl_r <= 8'h00;
				seq_r <= 16'h0000;
				sum_r <= 12'h000;
				ok_r <= '0;
				push_r <= 1'b0;
				entry_r <= '0;
			end else if (ce) begin
				armed_r <= armed_nxt;
				seen_r <= seen_nxt;
				hact_r <= hact_nxt;
				rel_r <= rel_nxt;
				hrel_r <= hrel_nxt;
				prev_r <= prev_nxt;
				b0_r <= b0_nxt;
				b1_r <= b1_nxt;
				ctl_r <= ctl_nxt;
				seq_r <= seq_nxt;
				sum_r <= sum_nxt;
				ok_r <= ok_nxt;
				push_r <= push_nxt;
				entry_r <= entry_nxt;
			end
		end

		ts_queue #(.WIDTH($bits(ptp_qual_pkg::entry_t)), .DEPTH(QDEPTH)) queue_i (
			.sys_clk(sys_clk),
			.rst(rst),
			.ce(ce),
			.push(push_r),
			.push_data(entry_r),
			.pop(q_pop[d]),
			.head(q_head[d]),
			.not_empty(q_ne[d]),
			.full(q_full[d]),
			.overflow(q_ovf[d])
		);

		queue_gate_a: assert property (@(posedge sys_clk) disable iff (rst)
			(ce && push_r) |-> dir_en[entry_r.mtype[2:0]])
			else $error("queue write for a disabled message type");
		source_check_a: assert property (@(posedge sys_clk) disable iff (rst)
			(ce && push_r && d == 1 && source_check_enable_r) |-> entry_r.hash == exp_hash_r)
			else $error("ingress entry with unexpected identity code");
		and_reject_a: assert property (@(posedge sys_clk) disable iff (rst)
			(ce && s_valid[d] && s_eop[d] && !cmb_or_r && !s_fixed_qual[d]) |=> !push_r)
			else $error("and mode queued a packet the fixed matcher rejected");
		v1_event_a: assert property (@(posedge sys_clk) disable iff (rst)
			(ce && s_valid[d] && s_eop[d] && b1_nxt[3:0] == `PTP_V1 && ctl_nxt[3:1] != 3'h0)
			|=> !push_r)
			else $error("version 1 non-event type was queued");
	end
endmodule
`default_nettype wire

//--- verilog/ts_queue.sv
// eight-entry timestamp identity queue with overflow detection
`timescale 1ns/1ps
`default_nettype none
module ts_queue #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 8
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic push,
	input wire logic [WIDTH-1:0] push_data,
	input wire logic pop,
	output logic [WIDTH-1:0] head,
	output logic not_empty,
	output logic full,
	output logic overflow
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
	logic [AW:0] cnt_r, cnt_nxt;
	logic do_push, do_pop;

	always_comb begin
		do_pop = pop && (cnt_r != '0);
		do_push = push && ((cnt_r != DEPTH_C) || do_pop);
		overflow = push && !do_push;
		wp_nxt = do_push ? wp_r + 1'b1 : wp_r;
		rp_nxt = do_pop ? rp_r + 1'b1 : rp_r;
		cnt_nxt = cnt_r;
		if (do_push && !do_pop) begin
			cnt_nxt = cnt_r + 1'b1;
		end else if (do_pop && !do_push) begin
			cnt_nxt = cnt_r - 1'b1;
		end
		head = mem[rp_r];
		not_empty = (cnt_r != '0);
		full = (cnt_r == DEPTH_C);
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
		end else if (ce) begin
			wp_r <= wp_nxt;
			rp_r <= rp_nxt;
			cnt_r <= cnt_nxt;
			if (do_push) begin
				mem[wp_r] <= push_data;
			end
		end
	end

	queue_bound_a: assert property (@(posedge sys_clk) disable iff (rst)
		(ce && full && push && !pop) |=> (cnt_r == DEPTH_C) && $stable(wp_r))
		else $error("push into a full queue changed its contents");
endmodule
`default_nettype wire
